//--- design/indicator_status_consts.vh
/*
 * Named constants of the indicator status monitor: status codes,
 * event signal positions and the time base.
 * Assumes inclusion by its bare name from the design file.
 */
`ifndef INDICATOR_STATUS_CONSTS_VH
`define INDICATOR_STATUS_CONSTS_VH

// ----------------------------------------------------------------
// Status codes
// ----------------------------------------------------------------
`define ST_INTERMEDIATE 2'h0
`define ST_OPEN 2'h1
`define ST_CLOSED 2'h2
`define ST_BAD 2'h3

// ----------------------------------------------------------------
// Event signal index, same encoding as the status codes
// ----------------------------------------------------------------
`define SIGS_PER_IND 4
`define EVTS_PER_IND 8
`define EVT_SHIFT 3

// ----------------------------------------------------------------
// Time base
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
`define STAMP_RES_NS 1_000_000
`define MS_CYCLES (`STAMP_RES_NS / `CLK_PERIOD_NS)
`define STAMP_W 32
`define NUM_IND 10

`endif

//--- design/indicator_status_monitor.v
/*
 * Indicator status monitor: decodes an open and a close contact per
 * indicator into open, closed, intermediate or bad, and emits filtered,
 * millisecond time-stamped on and off events, one per handshake.
 * Assumes all inputs synchronous to sys_clk; the event sink may stall.
 */
`include "indicator_status_consts.vh"

// Functional notes
// - Neither input active reports intermediate.
// - Both inputs active reports bad.
// - Logic one means active; only open gives open, only close gives closed.
// - Status only; no open or close command outputs exist.
// - On and off event per status signal, stamped at 1 ms resolution.
// - Per event on-only, off-only or both; unselected events discarded.
// - Up to ten independent instances numbered 1 to 10.
// - Selections load only in setup and hold while monitoring runs.
module indicator_status_monitor #(
    parameter NUM_IND = `NUM_IND,
    parameter STAMP_W = `STAMP_W,
    parameter MS_CYCLES = `MS_CYCLES
) (
    input wire sys_clk,
    input wire rst,
    input wire [NUM_IND-1:0] openIn,
    input wire [NUM_IND-1:0] closeIn,
    input wire setupMode,
    input wire [`SIGS_PER_IND*NUM_IND-1:0] cfgOnSel,
    input wire [`SIGS_PER_IND*NUM_IND-1:0] cfgOffSel,
    output wire [2*NUM_IND-1:0] statusCode,
    output wire evtValid,
    input wire evtReady,
    output wire [3:0] evtInst,
    output wire [1:0] evtSig,
    output wire evtOn,
    output wire [STAMP_W-1:0] evtStamp,
    output wire [STAMP_W-1:0] nowStamp
);

    localparam NEV = `EVTS_PER_IND * NUM_IND;
    localparam IW = $clog2(NEV);
    localparam CW = $clog2(MS_CYCLES);

    // ----------------------------------------------------------------
    // Millisecond time base
    // ----------------------------------------------------------------
    reg [CW-1:0] tickCnt_reg;
    reg [STAMP_W-1:0] stamp_reg;

    // Divider gives a one-cycle enable per ms
    // Stamp wraps silently after 2**STAMP_W ms; the sink must allow for it
    always @(posedge sys_clk) begin
        if (rst) begin
            tickCnt_reg <= {CW{1'b0}};
            stamp_reg <= {STAMP_W{1'b0}};
        end else if (tickCnt_reg == MS_CYCLES[CW-1:0] - 1'b1) begin
            tickCnt_reg <= {CW{1'b0}};
            stamp_reg <= stamp_reg + 1'b1;
        end else begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
        end
    end

    assign nowStamp = stamp_reg;

    // ----------------------------------------------------------------
    // Static event selection
    // ----------------------------------------------------------------
    reg [`SIGS_PER_IND*NUM_IND-1:0] onSel_reg;
    reg [`SIGS_PER_IND*NUM_IND-1:0] offSel_reg;

    // Held outside setup so filtering cannot shift under a running monitor
    always @(posedge sys_clk) begin
        if (rst) begin
            onSel_reg <= {`SIGS_PER_IND*NUM_IND{1'b1}};
            offSel_reg <= {`SIGS_PER_IND*NUM_IND{1'b1}};
        end else if (setupMode) begin
            onSel_reg <= cfgOnSel;
            offSel_reg <= cfgOffSel;
        end
    end

    // ----------------------------------------------------------------
    // Signals between the indicators and the arbiter
    // ----------------------------------------------------------------
    wire [NEV-1:0] pendVec;
    wire [STAMP_W*NUM_IND-1:0] stampFlat;
    reg [NEV-1:0] clrVec;
    reg [IW-1:0] sel;
    reg anyPend;
    reg load;

    // ----------------------------------------------------------------
    // Per-indicator decode, change detect and pending events
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_IND; g = g + 1) begin : ind
            reg [1:0] status_reg;
            reg [1:0] prev_reg;
            reg [`EVTS_PER_IND-1:0] pend_reg;
            reg [`EVTS_PER_IND-1:0] pend_next;
            reg [STAMP_W-1:0] stampInd_reg;
            reg [1:0] status_next;
            wire changed;
            wire [3:0] onMask;
            wire [3:0] offMask;
            integer k;

            // Reset status matches an idle contact pair, so no event follows reset
            // Decode from the two contacts, every cycle
            always @* begin
                case ({closeIn[g], openIn[g]})
                    2'h0: status_next = `ST_INTERMEDIATE;
                    2'h1: status_next = `ST_OPEN;
                    2'h2: status_next = `ST_CLOSED;
                    2'h3: status_next = `ST_BAD;
                    default: status_next = `ST_INTERMEDIATE;
                endcase
            end

            assign changed = (status_reg != prev_reg) && !setupMode;
            assign onMask = onSel_reg[g*`SIGS_PER_IND +: `SIGS_PER_IND];
            assign offMask = offSel_reg[g*`SIGS_PER_IND +: `SIGS_PER_IND];

            // Pending bits; a new event wins over a same-cycle clear
            always @* begin
                pend_next = pend_reg & ~clrVec[g*`EVTS_PER_IND +: `EVTS_PER_IND];
                for (k = 0; k < `SIGS_PER_IND; k = k + 1) begin
                    if (changed && status_reg == k[1:0] && onMask[k]) begin
                        pend_next[2*k+1] = 1'b1;
                    end
                    if (changed && prev_reg == k[1:0] && offMask[k]) begin
                        pend_next[2*k] = 1'b1;
                    end
                end
            end

            // Status updates each cycle; pending bits follow one cycle later, evtValid two cycles later
            always @(posedge sys_clk) begin
                if (rst) begin
                    status_reg <= `ST_INTERMEDIATE;
                    prev_reg <= `ST_INTERMEDIATE;
                    pend_reg <= {`EVTS_PER_IND{1'b0}};
                    stampInd_reg <= {STAMP_W{1'b0}};
                end else begin
                    status_reg <= status_next;
                    prev_reg <= status_reg;
                    pend_reg <= pend_next;
                    if (changed) begin
                        stampInd_reg <= stamp_reg;
                    end
                end
            end

            assign statusCode[2*g +: 2] = status_reg;
            assign pendVec[g*`EVTS_PER_IND +: `EVTS_PER_IND] = pend_reg;
            assign stampFlat[g*STAMP_W +: STAMP_W] = stampInd_reg;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Event output stage
    // ----------------------------------------------------------------
    reg valid_reg;
    reg [3:0] inst_reg;
    reg [1:0] sig_reg;
    reg on_reg;
    reg [STAMP_W-1:0] evStamp_reg;
    wire [IW-1:0] selInd;
    integer i;

    // Indicator index of the chosen bit, cut on purpose to the 4-bit number
    assign selInd = sel >> `EVT_SHIFT;

    // Lowest pending wins: indicator 1 first, then lower status code, off before on within one code
    // Only the taken bit clears, so later events keep their place
    always @* begin
        sel = {IW{1'b0}};
        anyPend = 1'b0;
        clrVec = {NEV{1'b0}};
        for (i = NEV - 1; i >= 0; i = i - 1) begin
            if (pendVec[i]) begin
                sel = i[IW-1:0];
                anyPend = 1'b1;
            end
        end
        load = anyPend && (!valid_reg || evtReady);
        if (load) begin
            clrVec[sel] = 1'b1;
        end
    end

    // Held until the sink takes it
    always @(posedge sys_clk) begin
        if (rst) begin
            valid_reg <= 1'b0;
            inst_reg <= 4'h0;
            sig_reg <= 2'h0;
            on_reg <= 1'b0;
            evStamp_reg <= {STAMP_W{1'b0}};
        end else if (load) begin
            valid_reg <= 1'b1;
            inst_reg <= selInd[3:0] + 4'h1;
            sig_reg <= sel[2:1];
            on_reg <= sel[0];
            evStamp_reg <= stampFlat[selInd*STAMP_W +: STAMP_W];
        end else if (evtReady) begin
            valid_reg <= 1'b0;
        end
    end

    // No command outputs by design; status and events only
    assign evtValid = valid_reg;
    assign evtInst = inst_reg;
    assign evtSig = sig_reg;
    assign evtOn = on_reg;
    assign evtStamp = evStamp_reg;

endmodule

//--- testbench/contact_model.sv
/* Switchgear auxiliary contact model for all ten indicators.
   Assumes the bench changes posReq just after a rising clock edge. */
module contact_model (
    input logic sys_clk,
    input logic [19:0] posReq,
    input logic singleSrc,
    output logic [9:0] openIn = 10'h000,
    output logic [9:0] closeIn = 10'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    // Contacts settle one clock after the request, like a slow relay
    always @(posedge sys_clk) begin
        for (int g = 0; g < 10; g++) begin
            openIn[g] <= posReq[2*g];
            closeIn[g] <= posReq[2*g+1];
        end
        // One source and its inverse on the last indicator
        if (singleSrc)
            closeIn[9] <= !posReq[18];
    end
endmodule

//--- testbench/status_events_monitor.sv
/* Port-level assertions of the indicator status monitor.
   Assumes it is bound into that module and shares its parameters. */
module status_events_monitor #(
    parameter NUM_IND = 10,
    parameter STAMP_W = 32,
    parameter MS_CYCLES = 10
) (
    input wire sys_clk,
    input wire rst,
    input wire [NUM_IND-1:0] openIn,
    input wire [NUM_IND-1:0] closeIn,
    input wire setupMode,
    input wire [4*NUM_IND-1:0] cfgOnSel,
    input wire [4*NUM_IND-1:0] cfgOffSel,
    input wire [2*NUM_IND-1:0] statusCode,
    input wire evtValid,
    input wire evtReady,
    input wire [3:0] evtInst,
    input wire [1:0] evtSig,
    input wire evtOn,
    input wire [STAMP_W-1:0] evtStamp,
    input wire [STAMP_W-1:0] nowStamp
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Quiet bus, all events selected, so a change must surface
    sequence quietChange;
        !evtValid && $changed(statusCode) && !setupMode && &cfgOnSel && &cfgOffSel;
    endsequence
    sequence stalled;
        evtValid && !evtReady;
    endsequence
    a_inter_decode: assert property (!openIn[0] && !closeIn[0] |=> statusCode[1:0] == 2'h0)
        else $error("intermediate not decoded");
    a_bad_decode: assert property (openIn[0] && closeIn[0] |=> statusCode[1:0] == 2'h3)
        else $error("bad not decoded");
    a_open_decode: assert property (openIn[0] && !closeIn[0] |=> statusCode[1:0] == 2'h1)
        else $error("open not decoded");
    a_last_inst: assert property (!openIn[NUM_IND-1] && closeIn[NUM_IND-1] |=>
        statusCode[2*NUM_IND-1 -: 2] == 2'h2) else $error("last indicator wrong");
    a_evt_hold: assert property (stalled |=> evtValid && $stable({evtInst, evtSig, evtOn, evtStamp}))
        else $error("event changed while stalled");
    a_stamp_step: assert property ($changed(nowStamp) |-> nowStamp == $past(nowStamp) + 1'b1)
        else $error("stamp skipped");
    a_stamp_period: assert property ($changed(nowStamp) |=> $stable(nowStamp) [*8])
        else $error("stamp ticks too fast");
    a_evt_latency: assert property (quietChange ##1 !setupMode |=> evtValid)
        else $error("event late");
    a_off_select: assert property (evtValid && !setupMode && !evtOn |->
        cfgOffSel[{evtInst - 4'h1, evtSig}]) else $error("unselected off event");
    a_on_select: assert property (evtValid && !setupMode && evtOn |->
        cfgOnSel[{evtInst - 4'h1, evtSig}]) else $error("unselected on event");
    a_stamp_fresh: assert property ($rose(evtValid) |-> nowStamp - evtStamp <= 32'h1)
        else $error("event stamp stale");
endmodule
bind indicator_status_monitor status_events_monitor #(.NUM_IND(NUM_IND), .STAMP_W(STAMP_W),
    .MS_CYCLES(MS_CYCLES)) chk_u (.sys_clk(sys_clk), .rst(rst), .openIn(openIn),
    .closeIn(closeIn), .setupMode(setupMode), .cfgOnSel(cfgOnSel), .cfgOffSel(cfgOffSel),
    .statusCode(statusCode), .evtValid(evtValid), .evtReady(evtReady), .evtInst(evtInst),
    .evtSig(evtSig), .evtOn(evtOn), .evtStamp(evtStamp), .nowStamp(nowStamp));

//--- testbench/indicator_status_monitor_tb.sv
/* Self-checking bench of the indicator status monitor.
   Assumes the contact model on its inputs and a ten-cycle ms tick. */
`define CHK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin nErrors++; \
    $display("FAIL t=%0t got %h exp %h", $time, got, exp); end end
module indicator_status_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst = 1, setupMode = 0, evtReady = 1, singleSrc = 0;
    logic [19:0] posReq = 20'h0_0000;
    logic [39:0] cfgOnSel = 40'hff_ffff_ffff, cfgOffSel = 40'hff_ffff_ffff;
    logic [9:0] openIn, closeIn;
    logic [19:0] statusCode;
    logic evtValid, evtOn;
    logic [3:0] evtInst;
    logic [1:0] evtSig;
    logic [31:0] evtStamp, offStamp;
    int nErrors = 0, cmpCount = 0;
    // 20 MHz system clock
    always #25 sys_clk = ~sys_clk;
    contact_model pm_u (.sys_clk(sys_clk), .posReq(posReq), .singleSrc(singleSrc),
        .openIn(openIn), .closeIn(closeIn));
    // Short ms tick keeps stamp checks within a brief run
    indicator_status_monitor #(.MS_CYCLES(10)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .openIn(openIn), .closeIn(closeIn), .setupMode(setupMode), .cfgOnSel(cfgOnSel),
        .cfgOffSel(cfgOffSel), .statusCode(statusCode), .evtValid(evtValid),
        .evtReady(evtReady), .evtInst(evtInst), .evtSig(evtSig), .evtOn(evtOn),
        .evtStamp(evtStamp), .nowStamp());
    task endOfTest;
        $display("Comparisons %0d, mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask
    // Bounded waits, so a silent design cannot hang the run
    task waitValid;
        for (int i = 0; i < 20 && evtValid !== 1'b1; i++)
            tick(1);
        `CHK(evtValid, 1'b1)
    endtask
    task drain;
        evtReady = 1;
        tick(4);
        for (int i = 0; i < 100 && evtValid !== 1'b0; i++)
            tick(1);
        `CHK(evtValid, 1'b0)
    endtask
    // All four codes on the first and last indicator, then one source
    task decodeCases;
        for (int c = 3; c >= 0; c--) begin
            posReq = {2'(c), 16'h0000, 2'(c)};
            tick(2);
            `CHK(statusCode[1:0], 2'(c))
            `CHK(statusCode[19:18], 2'(c))
        end
        singleSrc = 1;
        for (int b = 1; b >= 0; b--) begin
            posReq[18] = b[0];
            tick(2);
            `CHK(statusCode[19:18], (b == 1) ? 2'h1 : 2'h2)
        end
        singleSrc = 0;
        posReq = 20'h0_0000;
        drain;
    endtask
    // Stalled sink: off of old status, then on of new, same stamp
    task eventPair;
        evtReady = 0;
        posReq[3:2] = 2'h1;
        waitValid;
        `CHK({evtInst, evtSig, evtOn}, 7'h10)
        offStamp = evtStamp;
        tick(3);
        `CHK(evtValid, 1'b1)
        evtReady = 1;
        tick(1);
        `CHK({evtInst, evtSig, evtOn}, 7'h13)
        `CHK(evtStamp, offStamp)
        tick(1);
        `CHK(evtValid, 1'b0)
    endtask
    // Setup hides changes; indicator 3 closed-off and intermediate-on deselected
    task filterSetup;
        setupMode = 1;
        cfgOffSel[10] = 1'b0;
        cfgOnSel[8] = 1'b0;
        posReq[5:4] = 2'h2;
        tick(4);
        `CHK(evtValid, 1'b0)
        `CHK(statusCode[5:4], 2'h2)
        setupMode = 0;
        posReq[5:4] = 2'h1;
        waitValid;
        `CHK({evtInst, evtSig, evtOn}, 7'h1b)
        tick(1);
        `CHK(evtValid, 1'b0)
        // Off-only: open-off passes, intermediate-on is dropped
        posReq[5:4] = 2'h0;
        waitValid;
        `CHK({evtInst, evtSig, evtOn}, 7'h1a)
        tick(1);
        `CHK(evtValid, 1'b0)
        setupMode = 1;
        cfgOnSel = 40'hff_ffff_ffff;
        cfgOffSel = 40'hff_ffff_ffff;
        tick(1);
        setupMode = 0;
        drain;
    endtask
    initial begin
        tick(12);
        rst = 0;
        decodeCases;
        eventPair;
        filterSetup;
        endOfTest;
    end
    // Watchdog well beyond the sixty-odd cycles the tests need
    initial begin
        #200000;
        nErrors++;
        endOfTest;
    end
endmodule
